// ===== dv/sensor_status_multifunction_io_test.sv
`timescale 1ns/1ps
module sensor_status_multifunction_io_test
    import ssm_pkg::*;
;
    logic clk, rst, objRdValid, objError, pointOneOut, pointOneDriveN, outputTwo, extIn;
    logic laserOff, useExtrapolated, presetStatic, err, pointOneIn;
    logic [15:0] objRdData, statusWord, rd, speedThreshold;
    ssm_req_t objReq;
    ssm_cond_t cond;
    logic signed [31:0] distance, distThreshold;
    logic [31:0] distHysteresis;
    logic signed [15:0] velocity;
    logic [1:0] speedDirection;
    logic [4:0] serviceSelect;
    int errorCnt, testsRun, cycles, pulses;
    int dists[3] = '{100, 45, 39};
    int vels[5] = '{-600, -450, -399, -600, -600};
    logic [1:0] dirs[5] = '{DIR_BOTH, DIR_BOTH, DIR_BOTH, DIR_POS, DIR_NEG};
    logic exps[5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};

    // pin level from both parties
    assign pointOneIn = pointOneDriveN ? extIn : pointOneOut;

    ssm_status_mf i_dut (.clk(clk), .rst(rst), .objReq(objReq), .objRdData(objRdData),
        .objRdValid(objRdValid), .objError(objError), .cond(cond), .distance(distance),
        .distThreshold(distThreshold), .distHysteresis(distHysteresis), .velocity(velocity),
        .speedThreshold(speedThreshold), .speedDirection(speedDirection),
        .serviceSelect(serviceSelect), .pointOneIn(pointOneIn), .pointOneOut(pointOneOut),
        .pointOneDriveN(pointOneDriveN), .outputTwo(outputTwo), .statusWord(statusWord),
        .laserOff(laserOff), .useExtrapolated(useExtrapolated), .presetStatic(presetStatic));
    ssm_master_model i_master (.clk(clk), .objReq(objReq), .objRdData(objRdData),
        .objError(objError));

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic finalReport();
        $display("comparisons %0d mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finalReport
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            errorCnt++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [15:0] val, input logic expErr);
        i_master.access(wr, idx, sub, val, rd, err);
        chk({15'h0000, err}, {15'h0000, expErr});
        if (!wr && !expErr) begin
            chk(rd, val);
        end
    endtask : acc
    task automatic pinChk(input logic exp);
        cyc(3);
        chk({15'h0000, pointOneOut}, {15'h0000, exp});
        chk({15'h0000, statusWord[2]}, {15'h0000, exp});
    endtask : pinChk
    function automatic logic [15:0] expWord(input logic [9:0] c);
        return {c[9:2], c[1] | c[7], 3'h0, |c[9:6], 1'b0, c[0], 1'b0};
    endfunction : expWord

    // clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errorCnt++;
            finalReport();
        end
    end

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        rst = 1'b1; cond = '0; distance = '0; distThreshold = 32'sd50; distHysteresis = 32'd10;
        velocity = '0; speedThreshold = 16'h01F4; speedDirection = DIR_BOTH;
        serviceSelect = 5'h00; extIn = 1'b1;
        cyc(4);
        rst = 1'b0;
        chk({15'h0000, pointOneDriveN}, 16'h0001);
        acc(1'b0, OBJ_SETUP, SUB_ENABLE, 16'h0001, 1'b0);
        acc(1'b0, OBJ_SETUP, SUB_FUNCTION, 16'h0000, 1'b0);
        acc(1'b0, OBJ_SETUP, SUB_ACTIVE, 16'h0001, 1'b0);
        acc(1'b0, 16'h4009, 8'h01, 16'h0000, 1'b1);
        acc(1'b1, OBJ_STATUS, 8'h00, 16'hFFFF, 1'b1);
        for (int i = 0; i < 10; i++) begin
            cond = ssm_cond_t'(10'h001 << i);
            cyc(4);
            chk(statusWord, expWord(cond));
            chk({15'h0000, useExtrapolated}, {15'h0000, cond.plausWarn});
            chk({15'h0000, outputTwo}, {15'h0000, |cond[9:6]});
            acc(1'b0, OBJ_STATUS, 8'h00, expWord(cond), 1'b0);
        end
        cond = '0;
        // laser switched off and on again by the command word
        acc(1'b1, OBJ_COMMAND, 8'h00, 16'h0001, 1'b0);
        cyc(2);
        chk({13'h0000, laserOff, statusWord[7], statusWord[0]}, 16'h0007);
        acc(1'b0, OBJ_COMMAND, 8'h00, 16'h0001, 1'b0);
        acc(1'b1, OBJ_COMMAND, 8'h00, 16'h0000, 1'b0);
        cyc(2);
        chk({13'h0000, laserOff, statusWord[7], statusWord[0]}, 16'h0000);
        acc(1'b1, OBJ_SETUP, SUB_ACTIVE, 16'h0000, 1'b0);
        for (int k = 0; k < 3; k++) begin
            distance = 32'(dists[k]);
            pinChk(k < 2);
        end
        chk({15'h0000, pointOneDriveN}, 16'h0000);
        acc(1'b1, OBJ_SETUP, SUB_FUNCTION, 16'h0001, 1'b0);
        for (int k = 0; k < 5; k++) begin
            speedDirection = dirs[k];
            velocity = 16'(vels[k]);
            pinChk(exps[k]);
        end
        acc(1'b1, OBJ_SETUP, SUB_FUNCTION, 16'h0002, 1'b0);
        serviceSelect = 5'h01;
        cond.laserWarn = 1'b1;
        pinChk(1'b1);
        serviceSelect = 5'h02;
        pinChk(1'b0);
        cond = '0;
        acc(1'b1, OBJ_SETUP, SUB_FUNCTION, 16'h0003, 1'b0);
        cyc(3);
        chk({11'h000, laserOff, pointOneDriveN, statusWord[7], statusWord[2], statusWord[0]},
            16'h001F);
        extIn = 1'b0;
        cyc(3);
        chk({15'h0000, laserOff}, 16'h0000);
        acc(1'b1, OBJ_SETUP, SUB_FUNCTION, 16'h0004, 1'b0);
        pulses = 0;
        extIn = 1'b1;
        repeat (6) begin
            @(negedge clk);
            pulses += int'(presetStatic);
        end
        chk(16'(pulses), 16'h0001);
        acc(1'b1, OBJ_SETUP, SUB_FUNCTION, 16'h0000, 1'b0);
        distance = 32'sd100;
        cond.laserEol = 1'b1;
        acc(1'b1, OBJ_SETUP, SUB_ENABLE, 16'h0000, 1'b0);
        extIn = 1'b0;
        cyc(3);
        chk({11'h000, pointOneOut, pointOneDriveN, outputTwo, statusWord[3:2]},
            16'h0008);
        // input function while disabled: active input level must be ignored
        acc(1'b1, OBJ_SETUP, SUB_FUNCTION, 16'h0003, 1'b0);
        extIn = 1'b1;
        cyc(3);
        chk({14'h0000, laserOff, statusWord[2]}, 16'h0000);
        acc(1'b1, OBJ_SETUP, SUB_ENABLE, 16'h0001, 1'b0);
        cyc(3);
        chk({14'h0000, outputTwo, statusWord[3]}, 16'h0003);
        finalReport();
    end
endmodule : sensor_status_multifunction_io_test

bind ssm_status_mf ssm_status_mf_assertions i_chk (.clk(clk), .rst(rst), .objReq(objReq),
    .objRdValid(objRdValid), .objError(objError), .cond(cond), .statusWord(statusWord),
    .laserOff(laserOff), .useExtrapolated(useExtrapolated), .presetStatic(presetStatic));

// ===== dv/ssm_master_model.sv
`timescale 1ns/1ps
module ssm_master_model
    import ssm_pkg::*;
(
    input  wire logic        clk,
    output ssm_req_t         objReq,
    input  wire logic [15:0] objRdData,
    input  wire logic        objError
);
    // idle port at start
    initial objReq = '0;

    // one request held for one taking edge, answer sampled a cycle later
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [15:0] wd, output logic [15:0] rd, output logic err);
        @(negedge clk);
        objReq <= {~wr, wr, idx, sub, wd};
        @(negedge clk);
        rd = objRdData;
        err = objError;
        objReq <= {2'b00, ~idx, ~sub, ~wd}; // released fields scrambled
    endtask : access
endmodule : ssm_master_model

// ===== dv/ssm_status_mf_assertions.sv
`timescale 1ns/1ps
module ssm_status_mf_assertions
    import ssm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire ssm_req_t    objReq,
    input  wire logic        objRdValid,
    input  wire logic        objError,
    input  wire ssm_cond_t   cond,
    input  wire logic [15:0] statusWord,
    input  wire logic        laserOff,
    input  wire logic        useExtrapolated,
    input  wire logic        presetStatic
);
    // ------------------------------------------------------------
    // status word, object port and output flag properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_read_answer: assert property (objReq.read |=> objRdValid)
        else $error("read request got no answer");
    a_idle_quiet: assert property (
        !objReq.read && !objReq.write |=> !objRdValid && !objError)
        else $error("answer without a request");
    a_status_ro: assert property (objReq.write && objReq.index == OBJ_STATUS |=> objError)
        else $error("write to status word not refused");
    a_reserved_zero: assert property (statusWord[6:4] == 3'h0)
        else $error("reserved status bits not zero");
    a_cond_bits: assert property (
        $past(!rst) |-> statusWord[15:8] == $past(cond[9:2]))
        else $error("error and warning bits do not follow conditions");
    a_heater_bit: assert property ($past(!rst) |-> statusWord[1] == $past(cond.heaterOn))
        else $error("heater bit does not follow heater");
    a_not_ready: assert property (
        $past(!rst) && $past(cond.hwNotReady || cond.tempError) |-> statusWord[7])
        else $error("not ready bit missing");
    a_off_ready: assert property (statusWord[0] |-> statusWord[7])
        else $error("laser off but ready");
    a_laser_bit: assert property ($rose(laserOff) |-> ##[0:2] statusWord[0])
        else $error("laser off bit late");
    a_extrap_flag: assert property (
        $past(!rst) |-> useExtrapolated == $past(cond.plausWarn))
        else $error("extrapolation flag does not follow warning");
    a_preset_pulse: assert property (presetStatic |=> !presetStatic)
        else $error("preset pulse longer than one cycle");
endmodule : ssm_status_mf_assertions

// ===== verilog/ssm_pkg.sv
package ssm_pkg;

    // ----------------------------------------------------------------
    // object indices and subindices
    // ----------------------------------------------------------------
    localparam logic [15:0] OBJ_COMMAND    = 16'h4006;
    localparam logic [15:0] OBJ_STATUS     = 16'h4007;
    localparam logic [15:0] OBJ_SETUP      = 16'h4008;
    localparam logic [7:0]  SUB_ENABLE     = 8'h01;
    localparam logic [7:0]  SUB_FUNCTION   = 8'h02;
    localparam logic [7:0]  SUB_ACTIVE     = 8'h03;

    // ----------------------------------------------------------------
    // status word bit positions
    // ----------------------------------------------------------------
    localparam int BIT_LASER_ERR   = 15;
    localparam int BIT_LEVEL_ERR   = 14;
    localparam int BIT_TEMP_ERR    = 13;
    localparam int BIT_PLAUS_ERR   = 12;
    localparam int BIT_LASER_WARN  = 11;
    localparam int BIT_LEVEL_WARN  = 10;
    localparam int BIT_TEMP_WARN   = 9;
    localparam int BIT_PLAUS_WARN  = 8;
    localparam int BIT_NOT_READY   = 7;
    localparam int BIT_OUT_TWO     = 3;
    localparam int BIT_POINT_ONE   = 2;
    localparam int BIT_HEATER      = 1;
    localparam int BIT_LASER_OFF   = 0;
    localparam int CMD_LASER_OFF   = 0;

    // ----------------------------------------------------------------
    // reset values and fixed figures
    // ----------------------------------------------------------------
    localparam logic [7:0]  RST_ENABLE     = 8'h01;
    localparam logic [7:0]  RST_FUNCTION   = 8'h00;
    localparam logic [7:0]  RST_ACTIVE     = 8'h01;
    localparam logic [15:0] SPEED_HYST_MMS = 16'h0064; // 100 mm/s

    // function select codes of point one
    localparam logic [7:0] FN_DISTANCE = 8'h00;
    localparam logic [7:0] FN_VELOCITY = 8'h01;
    localparam logic [7:0] FN_SERVICE  = 8'h02;
    localparam logic [7:0] FN_LASEROFF = 8'h03;
    localparam logic [7:0] FN_PRESET   = 8'h04;

    // speed direction codes
    localparam logic [1:0] DIR_POS  = 2'h0;
    localparam logic [1:0] DIR_NEG  = 2'h1;
    localparam logic [1:0] DIR_BOTH = 2'h2;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic laserEol;
        logic levelError;
        logic tempError;
        logic plausError;
        logic laserWarn;
        logic levelWarn;
        logic tempWarn;
        logic plausWarn;
        logic hwNotReady;
        logic heaterOn;
    } ssm_cond_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [15:0] index;
        logic [7:0]  subindex;
        logic [15:0] wrData;
    } ssm_req_t;

endpackage : ssm_pkg

// ===== verilog/ssm_status_mf.sv
`timescale 1ns/1ps
// Summary of operation
// - 16-bit status word, bit 0 least significant
// - bit 15: laser diode end of life
// - bit 14: signal attenuation too high
// - bit 13: outside temperature range
// - bit 12: no valid measurement computable
// - bit 11: laser replacement due soon
// - bit 10: attenuation at critical value
// - bit 9: internal temperature critical
// - bit 8: faulty values, extrapolated output
// - bit 7: high when not ready
// - bit 3: output two active
// - bit 2: point one active in or out
// - bit 1: heater running
// - bit 0: measuring laser switched off
// - enable 1 activates both points, default 1
// - function 0: distance threshold switching, default
// - function 1: speed limit in chosen direction
// - function 2: any enabled service warning set
// - function 3: input switches laser off
// - function 4: input triggers static preset
// - active level 0 high, 1 low, default 1
// - direction 0 positive, 1 negative, 2 both
// - speed comparison hysteresis fixed 100 mm/s
// - command bit 0 switches laser off
module ssm_status_mf
    import ssm_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire ssm_req_t           objReq,
    output logic [15:0]             objRdData,
    output logic                    objRdValid,
    output logic                    objError,
    input  wire ssm_cond_t          cond,
    input  wire logic signed [31:0] distance,
    input  wire logic signed [31:0] distThreshold,
    input  wire logic [31:0]        distHysteresis,
    input  wire logic signed [15:0] velocity,
    input  wire logic [15:0]        speedThreshold,
    input  wire logic [1:0]         speedDirection,
    input  wire logic [4:0]         serviceSelect,
    input  wire logic               pointOneIn,
    output logic                    pointOneOut,
    output logic                    pointOneDriveN,
    output logic                    outputTwo,
    output logic [15:0]             statusWord,
    output logic                    laserOff,
    output logic                    useExtrapolated,
    output logic                    presetStatic
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] status;
        logic        cmdLaserOff;
        logic [7:0]  mfEnable;
        logic [7:0]  fnSelect;
        logic [7:0]  activeLevel;
        logic        distOver;
        logic        speedOver;
        logic        inPrev;
        logic        oneOut;
        logic        oneDriveN;
        logic        twoOut;
        logic        laserOff;
        logic        extrap;
        logic        preset;
        logic [15:0] rdData;
        logic        rdValid;
        logic        err;
    } ssm_state_t;

    ssm_state_t state;
    ssm_state_t next_state;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // physical pin level for a logical activity
    function automatic logic pinLevel(input logic act, input logic [7:0] lvl);
        pinLevel = lvl[0] ? ~act : act;
    endfunction : pinLevel

    // magnitude of a signed speed, widened to avoid overflow
    function automatic logic [16:0] speedMag(input logic signed [15:0] v);
        logic signed [16:0] w;
        w        = 17'(v);
        speedMag = w[16] ? 17'(-w) : 17'(w);
    endfunction : speedMag

    // threshold latch with a lower release point
    function automatic logic hystLatch(input logic prev,
                                       input logic above,
                                       input logic below);
        hystLatch = above ? 1'b1 : (below ? 1'b0 : prev);
    endfunction : hystLatch

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic               enabled;
        logic               inActive;
        logic               isInput;
        logic               oneAct;
        logic               distAbove;
        logic               distBelow;
        logic signed [33:0] distLow;
        logic [16:0]        spd;
        logic [16:0]        spdOn;
        logic [16:0]        spdOff;
        logic               spdAbove;
        logic               spdBelow;
        logic               service;
        logic               laserIsOff;
        logic               errAny;
        enabled    = 1'b0;
        inActive   = 1'b0;
        isInput    = 1'b0;
        oneAct     = 1'b0;
        distAbove  = 1'b0;
        distBelow  = 1'b0;
        distLow    = '0;
        spd        = '0;
        spdOn      = '0;
        spdOff     = '0;
        spdAbove   = 1'b0;
        spdBelow   = 1'b0;
        service    = 1'b0;
        laserIsOff = 1'b0;
        errAny     = 1'b0;
        next_state = state;

        // point one enable and input sampling
        enabled  = (state.mfEnable == RST_ENABLE);
        isInput  = (state.fnSelect == FN_LASEROFF) ||
                   (state.fnSelect == FN_PRESET);
        inActive = enabled && isInput &&
                   (pinLevel(pointOneIn, state.activeLevel) == 1'b1);

        // distance compare with configured hysteresis
        distLow   = 34'(distThreshold) - 34'(distHysteresis);
        distAbove = (distance > distThreshold);
        distBelow = (34'(distance) < distLow);
        next_state.distOver = hystLatch(state.distOver, distAbove, distBelow);

        // speed compare in the selected direction
        unique case (speedDirection)
            DIR_POS:  spd = velocity[15] ? 17'h00000 : 17'(velocity);
            DIR_NEG:  spd = velocity[15] ? speedMag(velocity) : 17'h00000;
            default:  spd = speedMag(velocity);
        endcase
        spdOn  = 17'(speedThreshold);
        spdOff = (spdOn > 17'(SPEED_HYST_MMS)) ?
                 spdOn - 17'(SPEED_HYST_MMS) : 17'h00000;
        spdAbove = (spd > spdOn);
        spdBelow = (spd < spdOff);
        next_state.speedOver = hystLatch(state.speedOver, spdAbove, spdBelow);

        // service warnings selected for point one
        service = (serviceSelect[0] & cond.laserWarn)  |
                  (serviceSelect[1] & cond.levelWarn)  |
                  (serviceSelect[2] & cond.tempWarn)   |
                  (serviceSelect[3] & cond.plausWarn)  |
                  (serviceSelect[4] & state.status[BIT_NOT_READY]);

        // logical activity of point one as an output
        unique case (state.fnSelect)
            FN_DISTANCE: oneAct = state.distOver;
            FN_VELOCITY: oneAct = state.speedOver;
            FN_SERVICE:  oneAct = service;
            default:     oneAct = 1'b0;
        endcase
        oneAct = oneAct && enabled && !isInput;

        // pin drive: released while point one is an input
        next_state.oneDriveN = !enabled || isInput;
        next_state.oneOut    = enabled && !isInput ?
                               pinLevel(oneAct, state.activeLevel) : 1'b0;

        // output two reports any error while enabled
        errAny = cond.laserEol | cond.levelError | cond.tempError | cond.plausError;
        next_state.twoOut = enabled && errAny;

        // laser control from command and input
        laserIsOff = state.cmdLaserOff ||
                     (inActive && state.fnSelect == FN_LASEROFF);
        next_state.laserOff = laserIsOff;
        next_state.extrap   = cond.plausWarn;

        // static preset on the activating edge of the input
        next_state.inPrev = inActive && state.fnSelect == FN_PRESET;
        next_state.preset = inActive && state.fnSelect == FN_PRESET
                            && !state.inPrev;

        // status word assembly
        next_state.status                 = 16'h0000;
        next_state.status[BIT_LASER_ERR]  = cond.laserEol;
        next_state.status[BIT_LEVEL_ERR]  = cond.levelError;
        next_state.status[BIT_TEMP_ERR]   = cond.tempError;
        next_state.status[BIT_PLAUS_ERR]  = cond.plausError;
        next_state.status[BIT_LASER_WARN] = cond.laserWarn;
        next_state.status[BIT_LEVEL_WARN] = cond.levelWarn;
        next_state.status[BIT_TEMP_WARN]  = cond.tempWarn;
        next_state.status[BIT_PLAUS_WARN] = cond.plausWarn;
        next_state.status[BIT_NOT_READY]  = cond.hwNotReady | cond.tempError
                                            | laserIsOff;
        next_state.status[BIT_OUT_TWO]    = next_state.twoOut;
        next_state.status[BIT_POINT_ONE]  = inActive | oneAct;
        next_state.status[BIT_HEATER]     = cond.heaterOn;
        next_state.status[BIT_LASER_OFF]  = laserIsOff;

        // object writes
        next_state.rdValid = 1'b0;
        next_state.err     = 1'b0;
        if (objReq.write) begin
            if (objReq.index == OBJ_COMMAND) begin
                next_state.cmdLaserOff = objReq.wrData[CMD_LASER_OFF];
            end else if (objReq.index == OBJ_SETUP &&
                         objReq.subindex == SUB_ENABLE) begin
                next_state.mfEnable = objReq.wrData[7:0];
            end else if (objReq.index == OBJ_SETUP &&
                         objReq.subindex == SUB_FUNCTION) begin
                next_state.fnSelect = objReq.wrData[7:0];
            end else if (objReq.index == OBJ_SETUP &&
                         objReq.subindex == SUB_ACTIVE) begin
                next_state.activeLevel = objReq.wrData[7:0];
            end else begin
                next_state.err = 1'b1;
            end
        end

        // object reads
        if (objReq.read) begin
            next_state.rdValid = 1'b1;
            next_state.rdData  = 16'h0000;
            if (objReq.index == OBJ_STATUS) begin
                next_state.rdData = state.status;
            end else if (objReq.index == OBJ_COMMAND) begin
                next_state.rdData = {15'h0000, state.cmdLaserOff};
            end else if (objReq.index == OBJ_SETUP &&
                         objReq.subindex == SUB_ENABLE) begin
                next_state.rdData = {8'h00, state.mfEnable};
            end else if (objReq.index == OBJ_SETUP &&
                         objReq.subindex == SUB_FUNCTION) begin
                next_state.rdData = {8'h00, state.fnSelect};
            end else if (objReq.index == OBJ_SETUP &&
                         objReq.subindex == SUB_ACTIVE) begin
                next_state.rdData = {8'h00, state.activeLevel};
            end else begin
                next_state.err = 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state             <= '0;
            state.mfEnable    <= RST_ENABLE;
            state.fnSelect    <= RST_FUNCTION;
            state.activeLevel <= RST_ACTIVE;
            state.oneDriveN   <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign objRdData       = state.rdData;
    assign objRdValid      = state.rdValid;
    assign objError        = state.err;
    assign pointOneOut     = state.oneOut;
    assign pointOneDriveN  = state.oneDriveN;
    assign outputTwo       = state.twoOut;
    assign statusWord      = state.status;
    assign laserOff        = state.laserOff;
    assign useExtrapolated = state.extrap;
    assign presetStatic    = state.preset;

endmodule : ssm_status_mf
